/* File: ebc_map.vh */
// Purpose: Constants for the external bus and control pin block.
// Assumes: Included by bare name from the design files.
// Notes: Ratios count crystal periods per internal bus cycle.
`ifndef EBC_MAP_VH
`define EBC_MAP_VH

// Crystal periods per internal cycle for each clock input mode.
`define EBC_RATIO_DIRECT 3'h1
`define EBC_RATIO_FAST 3'h2
`define EBC_RATIO_SLOW 3'h4

// Reset vector location in external memory.
`define EBC_VECTOR_LO 16'hfffc
`define EBC_VECTOR_HI 16'hfffd

// Start-up sequencer states.
`define EBC_ST_HOLD 2'h0
`define EBC_ST_VLO 2'h1
`define EBC_ST_VHI 2'h2
`define EBC_ST_RUN 2'h3

// Kind of the bus cycle in progress.
`define EBC_CY_IDLE 2'h0
`define EBC_CY_CPU 2'h1
`define EBC_CY_VLO 2'h2
`define EBC_CY_VHI 2'h3

`endif

/* File: ebc_sync_edge.v */
// Purpose: Two-stage synchroniser with registered edge pulses.
// Assumes: One clock; synchronous active-high reset.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none

module ebc_sync_edge #(
	parameter RESET_LEVEL = 1'b1
) (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// Raw input
	input wire pinIn,
	// Synchronised level and edge pulses
	output reg level,
	output reg rise,
	output reg fall
);

reg stage1;
reg stage2;

always @(posedge sys_clk) begin
	if (srst) begin
		stage1 <= RESET_LEVEL;
		stage2 <= RESET_LEVEL;
		level <= RESET_LEVEL;
		rise <= 1'b0;
		fall <= 1'b0;
	end else begin
		stage1 <= pinIn;
		stage2 <= stage1;
		level <= stage2;
		rise <= stage2 & ~level;
		fall <= ~stage2 & level;
	end
end

endmodule // ebc_sync_edge

`default_nettype wire

/* File: ebc_bus_pins.v */
// Purpose: Expansion bus and control pins of a one-chip 8-bit computer.
// Assumes: CPU side issues one request per bus cycle through a slot.
// Notes: Bus cycles are paced by crystal edges, not by sys_clk.
//
// Contract
// - Read/write line high in bus reads, low in bus writes.
// - Opcode-fetch marker high for the whole fetch cycle, low otherwise.
// - Falling edge on the interrupt pin requests a non-maskable interrupt.
// - Address bits 0-12 and 15 on own lines; 13, 14 on port C.
// - Phase-two clock output runs at the internal cycle rate.
// - Grounded crystal output: direct clock; floating: four or two times.
// - Eight-bit data bus driven on writes, sampled on reads.
// - Port D is wholly input or wholly output.
// - After reset, fetch the start address from the reset vector.
`timescale 1ns/10ps
`default_nettype none
`include "ebc_map.vh"

module ebc_bus_pins (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// Straps and clock input
	input wire crystalOutGnd,
	input wire fastPart,
	input wire crystalInput,
	// Control pins
	input wire deviceInitInput_n,
	input wire nmiInput_n,
	// CPU-side request slot
	input wire reqValid,
	input wire [15:0] reqAddr,
	input wire reqWrite,
	input wire [7:0] reqData,
	input wire reqFetch,
	input wire wideMode,
	output reg reqReady,
	// CPU-side answers
	output reg [7:0] rdData,
	output reg rdValid,
	output reg [15:0] vectorAddr,
	output reg vectorValid,
	output reg nmiRequest,
	// Bus pins
	output reg [13:0] addressOutLines,
	output reg readWrite,
	output reg syncOut,
	output reg phaseTwo,
	input wire [7:0] externalDataLinesIn,
	output reg [7:0] externalDataLinesOut,
	output reg [7:0] externalDataLinesOe,
	// Port C upper bits
	input wire [1:0] portCUserOut,
	input wire [1:0] portCUserOe,
	output reg portCBitSixOut,
	output reg portCBitSixOe,
	output reg portCBitSevenOut,
	output reg portCBitSevenOe,
	// Port D
	input wire portDirOut,
	input wire [7:0] portDUser,
	input wire [7:0] portDLinesIn,
	output reg [7:0] portDLinesOut,
	output reg [7:0] portDLinesOe,
	output reg [7:0] portDRead
);

// Last crystal-edge index of a bus cycle: two edges per crystal period.
function [2:0] lastPhase;
	input [2:0] ratio;
	begin
		lastPhase = {ratio[1:0], 1'b0} - 3'h1;
	end
endfunction

// Index at which phase two rises: halfway through the cycle.
function [2:0] halfPhase;
	input [2:0] ratio;
	begin
		halfPhase = ratio;
	end
endfunction

wire xtalRise;
wire xtalFall;
wire nmiFall;
wire initLevel;

ebc_sync_edge #(.RESET_LEVEL(1'b0)) xtalSync (
	.sys_clk(sys_clk),
	.srst(srst),
	.pinIn(crystalInput),
	.level(),
	.rise(xtalRise),
	.fall(xtalFall)
);

ebc_sync_edge #(.RESET_LEVEL(1'b1)) nmiSync (
	.sys_clk(sys_clk),
	.srst(srst),
	.pinIn(nmiInput_n),
	.level(),
	.rise(),
	.fall(nmiFall)
);

ebc_sync_edge #(.RESET_LEVEL(1'b0)) initSync (
	.sys_clk(sys_clk),
	.srst(srst),
	.pinIn(deviceInitInput_n),
	.level(initLevel),
	.rise(),
	.fall()
);

reg [2:0] ratio;
reg [2:0] phase;
reg [1:0] seqState;
reg [1:0] cycKind;
reg cycWrite;
reg cycWide;
reg [15:0] cycAddr;
reg pendValid;
reg [15:0] pendAddr;
reg pendWrite;
reg [7:0] pendData;
reg pendFetch;
reg pendWide;

wire xtalEdge = xtalRise | xtalFall;
wire boundary = xtalEdge & (phase == lastPhase(ratio));
wire midpoint = xtalEdge & (phase == halfPhase(ratio) - 3'h1);
wire startCpu = boundary & (seqState == `EBC_ST_RUN) & pendValid;
wire takeReq = reqValid & reqReady;
wire next_pendValid = (pendValid & ~startCpu) | takeReq;

always @(posedge sys_clk) begin
	if (srst) begin
		// Strap sampled while reset is held; grounded output means direct.
		if (crystalOutGnd) begin
			ratio <= `EBC_RATIO_DIRECT;
		end else if (fastPart) begin
			ratio <= `EBC_RATIO_FAST;
		end else begin
			ratio <= `EBC_RATIO_SLOW;
		end
		phase <= 3'h0;
		phaseTwo <= 1'b0;
		seqState <= `EBC_ST_HOLD;
		cycKind <= `EBC_CY_IDLE;
		cycWrite <= 1'b0;
		cycWide <= 1'b0;
		cycAddr <= 16'h0000;
		pendValid <= 1'b0;
		pendAddr <= 16'h0000;
		pendWrite <= 1'b0;
		pendData <= 8'h00;
		pendFetch <= 1'b0;
		pendWide <= 1'b0;
		reqReady <= 1'b0;
		rdData <= 8'h00;
		rdValid <= 1'b0;
		vectorAddr <= 16'h0000;
		vectorValid <= 1'b0;
		nmiRequest <= 1'b0;
		addressOutLines <= 14'h0000;
		readWrite <= 1'b1;
		syncOut <= 1'b0;
		externalDataLinesOut <= 8'h00;
		externalDataLinesOe <= 8'h00;
		portCBitSixOut <= 1'b0;
		portCBitSixOe <= 1'b0;
		portCBitSevenOut <= 1'b0;
		portCBitSevenOe <= 1'b0;
		portDLinesOut <= 8'h00;
		portDLinesOe <= 8'h00;
		portDRead <= 8'h00;
	end else begin
		rdValid <= 1'b0;
		vectorValid <= 1'b0;
		nmiRequest <= nmiFall;
		// One direction input fans out to all eight lines.
		portDLinesOe <= {8{portDirOut}};
		portDLinesOut <= portDUser;
		portDRead <= portDLinesIn;
		if (xtalEdge) begin
			phase <= boundary ? 3'h0 : phase + 3'h1;
		end
		if (midpoint) begin
			phaseTwo <= 1'b1;
			if (cycWrite) begin
				externalDataLinesOe <= 8'hff;
			end
		end
		// Upper port C bits follow the user unless borrowed for address.
		if (cycWide) begin
			portCBitSixOut <= cycAddr[13];
			portCBitSevenOut <= cycAddr[14];
			portCBitSixOe <= 1'b1;
			portCBitSevenOe <= 1'b1;
		end else begin
			portCBitSixOut <= portCUserOut[0];
			portCBitSevenOut <= portCUserOut[1];
			portCBitSixOe <= portCUserOe[0];
			portCBitSevenOe <= portCUserOe[1];
		end
		if (takeReq) begin
			pendAddr <= reqAddr;
			pendWrite <= reqWrite;
			pendData <= reqData;
			pendFetch <= reqFetch;
			pendWide <= wideMode;
		end
		pendValid <= next_pendValid;
		reqReady <= (seqState == `EBC_ST_RUN) & ~next_pendValid;
		if (boundary) begin
			phaseTwo <= 1'b0;
			externalDataLinesOe <= 8'h00;
			// Read data is caught as phase two falls.
			case (cycKind)
			`EBC_CY_CPU: begin
				if (!cycWrite) begin
					rdData <= externalDataLinesIn;
					rdValid <= 1'b1;
				end
			end
			`EBC_CY_VLO: begin
				vectorAddr[7:0] <= externalDataLinesIn;
			end
			`EBC_CY_VHI: begin
				vectorAddr[15:8] <= externalDataLinesIn;
				vectorValid <= 1'b1;
			end
			default: begin
			end
			endcase
			// Next cycle: address and direction go out at its very start.
			cycWrite <= 1'b0;
			readWrite <= 1'b1;
			syncOut <= 1'b0;
			cycWide <= 1'b0;
			cycKind <= `EBC_CY_IDLE;
			case (seqState)
			`EBC_ST_HOLD: begin
				// Start-up waits for the init pin to be released high.
				if (initLevel) begin
					seqState <= `EBC_ST_VLO;
				end
			end
			`EBC_ST_VLO: begin
				cycKind <= `EBC_CY_VLO;
				cycAddr <= `EBC_VECTOR_LO;
				addressOutLines <= {1'b1, 13'h1ffc};
				seqState <= `EBC_ST_VHI;
			end
			`EBC_ST_VHI: begin
				cycKind <= `EBC_CY_VHI;
				cycAddr <= `EBC_VECTOR_HI;
				addressOutLines <= {1'b1, 13'h1ffd};
				seqState <= `EBC_ST_RUN;
			end
			`EBC_ST_RUN: begin
				if (pendValid) begin
					cycKind <= `EBC_CY_CPU;
					cycAddr <= pendAddr;
					cycWide <= pendWide;
					cycWrite <= pendWrite;
					readWrite <= ~pendWrite;
					syncOut <= pendFetch & ~pendWrite;
					externalDataLinesOut <= pendData;
					addressOutLines <= {pendAddr[15], pendAddr[12:0]};
				end
			end
			default: begin
				seqState <= `EBC_ST_HOLD;
			end
			endcase
		end
		// A low init pin forces the sequencer back to hold at once and closes the slot.
		if (!initLevel) begin
			seqState <= `EBC_ST_HOLD;
			reqReady <= 1'b0;
		end
	end
end

endmodule // ebc_bus_pins

`default_nettype wire

/* File: ebc_bus_chk.sv */
// Purpose: Port checks for the bus pin block.
// Assumes: Bound to ebc_bus_pins.
// Notes: Bus cycles are paced by crystal edges.
`timescale 1ns/10ps
`default_nettype none
module ebc_bus_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Watched ports
	input wire logic nmiInput_n,
	input wire logic reqValid,
	input wire logic reqReady,
	input wire logic rdValid,
	input wire logic nmiRequest,
	input wire logic readWrite,
	input wire logic syncOut,
	input wire logic phaseTwo,
	input wire logic [7:0] externalDataLinesOe,
	input wire logic portDirOut,
	input wire logic [7:0] portDLinesOe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence take; reqValid && reqReady; endsequence
	sequence nmiEdge; $fell(nmiInput_n); endsequence
	AST_TAKE: assert property (take |=> !reqReady)
		else $error("slot stayed open");
	AST_BOUNDARY: assert property ($changed({readWrite, syncOut}) |-> $fell(phaseTwo))
		else $error("direction moved off a boundary");
	AST_DRIVE: assert property (externalDataLinesOe != 8'h00 |-> externalDataLinesOe == 8'hff && !readWrite && phaseTwo)
		else $error("data driven out of place");
	AST_SYNC: assert property (syncOut |-> readWrite)
		else $error("fetch marker in a write");
	AST_NMI: assert property (nmiEdge |-> ##[1:8] nmiRequest)
		else $error("interrupt edge lost");
	AST_NMI_ONE: assert property (nmiRequest |=> !nmiRequest)
		else $error("interrupt pulse too long");
	AST_PORTD: assert property (portDLinesOe == 8'h00 || portDLinesOe == 8'hff)
		else $error("port D mixed");
	AST_PORTD_OUT: assert property ($rose(portDirOut) |-> ##[1:3] portDLinesOe == 8'hff)
		else $error("port D not output");
	AST_RD_ONE: assert property (rdValid |=> !rdValid)
		else $error("read pulse too long");
endmodule // ebc_bus_chk
`default_nettype wire

/* File: ebc_mem_model.sv */
// Purpose: External memory on the expansion bus.
// Assumes: Read data is wanted while phase two is high.
// Notes: An undriven bus shows the inverse of its last value.
`timescale 1ns/10ps
`default_nettype none
module ebc_mem_model (
	// Clock
	input wire logic sys_clk,
	// Bus pins
	input wire logic [13:0] addressOutLines,
	input wire logic readWrite,
	input wire logic phaseTwo,
	input wire logic [7:0] externalDataLinesOut,
	input wire logic [7:0] externalDataLinesOe,
	output var logic [7:0] memData
);
	logic [7:0] mem [0:255];
	logic [7:0] last = 8'h00;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
	// Holding stale data would hide a late sample, so it is inverted.
	always_comb memData = (readWrite && phaseTwo) ? mem[addressOutLines[7:0]] : ~last;
	always @(posedge sys_clk) begin
		if (readWrite && phaseTwo)
			last <= mem[addressOutLines[7:0]];
		if (externalDataLinesOe == 8'hff)
			mem[addressOutLines[7:0]] <= externalDataLinesOut;
	end
endmodule // ebc_mem_model
`default_nettype wire

/* File: external_bus_and_control_pins_bench.sv */
// Purpose: Self-checking bench for the bus pin block.
// Assumes: Each crystal level lasts three clocks.
// Notes: expMem shadows the memory model.
`timescale 1ns/10ps
`default_nettype none
module external_bus_and_control_pins_bench;
	logic sys_clk = 0, srst = 1, crystalOutGnd = 1, fastPart = 0;
	logic crystalInput = 0, deviceInitInput_n = 0, nmiInput_n = 1;
	logic reqValid = 0, reqWrite = 0, reqFetch = 0, wideMode = 0;
	logic [15:0] reqAddr = 0, vectorAddr;
	logic [7:0] reqData = 0, portDUser = 0, padIn = 0, memData, rdData;
	logic [1:0] portCUserOut = 0, portCUserOe = 0;
	logic portDirOut = 0, reqReady, rdValid, vectorValid, nmiRequest;
	logic readWrite, syncOut, phaseTwo, portCBitSixOut, portCBitSixOe;
	logic portCBitSevenOut, portCBitSevenOe;
	logic [13:0] addressOutLines;
	logic [7:0] externalDataLinesIn, externalDataLinesOut;
	logic [7:0] externalDataLinesOe, portDLinesIn, portDLinesOut;
	logic [7:0] portDLinesOe, portDRead;
	logic [7:0] expMem [0:255];
	logic [7:0] expRd [$];
	logic [31:0] seed = 56;
	int fails = 0, num_checks = 0;
	time t;
	always #12.5 sys_clk = ~sys_clk;
	always #75 crystalInput = ~crystalInput;
	assign externalDataLinesIn = (externalDataLinesOe & externalDataLinesOut)
		| (~externalDataLinesOe & memData);
	assign portDLinesIn = (portDLinesOe & portDLinesOut) | (~portDLinesOe & padIn);
	ebc_bus_pins i_ebc_bus_pins (.sys_clk, .srst, .crystalOutGnd, .fastPart,
		.crystalInput, .deviceInitInput_n, .nmiInput_n, .reqValid, .reqAddr,
		.reqWrite, .reqData, .reqFetch, .wideMode, .reqReady, .rdData, .rdValid,
		.vectorAddr, .vectorValid, .nmiRequest, .addressOutLines, .readWrite,
		.syncOut, .phaseTwo, .externalDataLinesIn, .externalDataLinesOut,
		.externalDataLinesOe, .portCUserOut, .portCUserOe, .portCBitSixOut,
		.portCBitSixOe, .portCBitSevenOut, .portCBitSevenOe, .portDirOut,
		.portDUser, .portDLinesIn, .portDLinesOut, .portDLinesOe, .portDRead);
	ebc_mem_model i_ebc_mem_model (.sys_clk, .addressOutLines, .readWrite,
		.phaseTwo, .externalDataLinesOut, .externalDataLinesOe, .memData);
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic waitFor(ref logic s, input logic v);
		int k;
		for (k = 0; k < 400 && s !== v; k++) @(negedge sys_clk);
		chk(16'(k < 400), 16'h0001);
	endtask
	task automatic busOp();
		logic [31:0] r, p;
		int k;
		r = rnd();
		p = rnd();
		{reqData, reqFetch, reqWrite, wideMode, reqAddr} = r[26:0];
		{portCUserOut, portCUserOe, portDirOut, portDUser, padIn} = p[20:0];
		reqValid = 1;
		// Ready is read off the edge, so the take edge is never raced.
		for (k = 0; k < 400 && reqReady !== 1'b1; k++) @(negedge sys_clk);
		chk(16'(k < 400), 16'h0001);
		@(negedge sys_clk);
		reqValid = 0;
		waitFor(phaseTwo, 1);
		waitFor(phaseTwo, 0);
		waitFor(phaseTwo, 1);
		chk(addressOutLines, {reqAddr[15], reqAddr[12:0]});
		chk(readWrite, !reqWrite);
		chk(syncOut, reqFetch & !reqWrite);
		chk(externalDataLinesOe, reqWrite ? 8'hff : 8'h00);
		chk({portCBitSixOut, portCBitSixOe, portCBitSevenOut, portCBitSevenOe},
			wideMode ? {reqAddr[13], 1'b1, reqAddr[14], 1'b1} : {portCUserOut[0],
			portCUserOe[0], portCUserOut[1], portCUserOe[1]});
		if (reqWrite) begin
			chk(externalDataLinesOut, reqData);
			expMem[reqAddr[7:0]] = reqData;
			waitFor(phaseTwo, 0);
		end else begin
			expRd.push_back(expMem[reqAddr[7:0]]);
			waitFor(rdValid, 1);
			chk(rdData, expRd.pop_front());
		end
		chk(portDLinesOe, {8{portDirOut}});
		chk(portDRead, portDirOut ? portDUser : padIn);
	endtask
	task complete_run();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		complete_run();
	end
	initial begin
		for (int i = 0; i < 256; i++) expMem[i] = 8'(i) ^ 8'h3c;
		for (int m = 0; m < 3; m++) begin
			@(negedge sys_clk);
			srst = 1;
			deviceInitInput_n = 0;
			crystalOutGnd = (m == 0);
			fastPart = (m == 1);
			repeat (3) @(negedge sys_clk);
			srst = 0;
			repeat (48 << m) @(negedge sys_clk);
			deviceInitInput_n = 1;
			waitFor(vectorValid, 1);
			chk(vectorAddr, {expMem[8'hfd], expMem[8'hfc]});
			waitFor(phaseTwo, 0);
			waitFor(phaseTwo, 1);
			t = $time;
			waitFor(phaseTwo, 0);
			waitFor(phaseTwo, 1);
			chk(16'(($time - t) / 25), 16'(6 << m));
			nmiInput_n = 0;
			waitFor(nmiRequest, 1);
			nmiInput_n = 1;
			for (int n = 0; n < 12; n++) busOp();
			$display("clock mode %0d done", m);
		end
		complete_run();
	end
endmodule // external_bus_and_control_pins_bench
bind ebc_bus_pins ebc_bus_chk i_ebc_bus_chk (.sys_clk, .srst, .nmiInput_n,
	.reqValid, .reqReady, .rdValid, .nmiRequest, .readWrite, .syncOut,
	.phaseTwo, .externalDataLinesOe, .portDirOut, .portDLinesOe);
`default_nettype wire
